/* File: design/clock_fanout_output_enables.sv */
// Clock fan-out with per-output enables loaded over a two-wire serial link
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// RULE1: Thirteen outputs copy the one input clock while enabled.
// RULE2: Outputs 0 to 11 feed memory modules; output 12 is PLL feedback.
// RULE3: Each output has its own enable bit loaded over the serial link.
// RULE4: After reset every enable bit is set, so all outputs run.
// RULE5: Bytes arrive from byte 0 upward, each byte most significant bit first.
// RULE6: The master writes zero into reserved and unused bit positions.
// RULE7: Device answers target address 1101001 followed by the direction bit.
// RULE8: Byte 0: bit 7 output 5, bit 6 output 4, bits 3..0 outputs 3..0.
// RULE9: Byte 1: bits 7..4 outputs 11..8, bits 1..0 outputs 7..6.
// RULE10: Byte 2: only bit 6 is used, enabling output 12.
// RULE11: Disabled outputs sit low; enable changes occur only between input pulses.
module clock_fanout_output_enables
  import clock_fanout_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic buf_in,
  input wire logic serial_clock_pin,
  input wire logic config_serial_data_pin_in,
  output logic config_serial_data_pin_out,
  output logic config_serial_data_pin_oe,
  output logic [NUM_MEMORY_OUTPUTS-1:0] fanout_out,
  output logic fanout_out_12
);

  ctrl_type q;
  ctrl_type next_q;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic byte_full;
  logic [NUM_OUTPUTS-1:0] gated;

  // ==========================================================
  // Byte to enable mapping
  // Reserved positions are dropped; the master is expected to send zero there.
  function automatic logic [NUM_OUTPUTS-1:0] apply_byte(
    input logic [NUM_OUTPUTS-1:0] cur,
    input logic [1:0] idx,
    input logic [7:0] data
  );
    logic [NUM_OUTPUTS-1:0] res;
    res = cur;
    unique case (idx)
      BYTE_LOW_GROUP: begin
        res[5] = data[LOW_OUT5_BIT]; // [RULE8]
        res[4] = data[LOW_OUT4_BIT]; // [RULE8]
        res[3:0] = data[LOW_OUT3_0_LSB +: 4]; // [RULE8]
      end
      BYTE_MID_GROUP: begin
        res[11:8] = data[MID_OUT11_8_LSB +: 4]; // [RULE9]
        res[7:6] = data[MID_OUT7_6_LSB +: 2]; // [RULE9]
      end
      BYTE_HIGH_GROUP: begin
        res[12] = data[HIGH_OUT12_BIT]; // [RULE10]
      end
      default: begin
        res = cur; // Bytes past the map are accepted and discarded
      end
    endcase
    return res;
  endfunction : apply_byte

  // ==========================================================
  // Link event detection on the second synchroniser stage
  assign scl_rise = q.scl_s2 & ~q.scl_d;
  assign scl_fall = ~q.scl_s2 & q.scl_d;
  assign start_seen = q.scl_s2 & q.scl_d & q.sda_d & ~q.sda_s2;
  assign stop_seen = q.scl_s2 & q.scl_d & ~q.sda_d & q.sda_s2;
  assign byte_full = (q.bit_cnt == BITS_PER_BYTE);

  // ==========================================================
  // Receiver next state
  // The link clock is oversampled by clk, so it needs no edge of its own.
  always_comb begin
    next_q = q;
    next_q.scl_s1 = serial_clock_pin;
    next_q.scl_s2 = q.scl_s1;
    next_q.scl_d = q.scl_s2;
    next_q.sda_s1 = config_serial_data_pin_in;
    next_q.sda_s2 = q.sda_s1;
    next_q.sda_d = q.sda_s2;
    next_q.buf_s1 = buf_in;
    next_q.buf_s2 = q.buf_s1;
    if (start_seen) begin
      // A start, repeated or not, always restarts from byte 0
      next_q.state = ST_ADDR;
      next_q.bit_cnt = 4'h0;
      next_q.byte_idx = BYTE_LOW_GROUP; // [RULE5]
      next_q.sda_drive = 1'h0;
    end else if (stop_seen) begin
      next_q.state = ST_IDLE;
      next_q.sda_drive = 1'h0;
    end else begin
      unique case (q.state)
        ST_IDLE: begin
          next_q.bit_cnt = 4'h0;
        end
        ST_ADDR, ST_DATA: begin
          if (scl_rise && !byte_full) begin
            next_q.shift = {q.shift[6:0], q.sda_s2}; // [RULE5]
            next_q.bit_cnt = q.bit_cnt + 4'h1;
          end else if (scl_fall && byte_full) begin
            if (q.state == ST_ADDR) begin
              // No read-back exists, so a read request is not acknowledged
              if (q.shift == {CFG_TARGET_ADDR, DIR_WRITE}) begin // [RULE7]
                next_q.state = ST_ADDR_ACK;
                next_q.sda_drive = 1'h1;
              end else begin
                next_q.state = ST_IDLE;
              end
            end else begin
              next_q.enable = apply_byte(q.enable, q.byte_idx, q.shift); // [RULE3]
              if (q.byte_idx != NUM_CFG_BYTES) begin
                next_q.byte_idx = q.byte_idx + 2'h1; // [RULE5]
              end
              next_q.state = ST_DATA_ACK;
              next_q.sda_drive = 1'h1;
            end
          end
        end
        ST_ADDR_ACK, ST_DATA_ACK: begin
          // Release the line on the falling edge that ends the ack slot
          if (scl_fall) begin
            next_q.sda_drive = 1'h0;
            next_q.bit_cnt = 4'h0;
            next_q.state = ST_DATA;
          end
        end
        default: begin
          next_q.state = ST_IDLE;
          next_q.sda_drive = 1'h0;
        end
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= CTRL_RESET; // [RULE4]
    end else begin
      q <= next_q;
    end
  end

  // ==========================================================
  // Output gating
  clock_gate_bank #(
    .WIDTH(NUM_OUTPUTS),
    .RESET_ENABLE(ENABLE_RESET)
  ) u_gate (
    .clk(clk),
    .rst_n(rst_n),
    .clk_level(q.buf_s2),
    .enable(q.enable),
    .gated(gated)
  );

  // Memory module clocks and the feedback clock leave on separate ports
  assign fanout_out = gated[NUM_MEMORY_OUTPUTS-1:0]; // [RULE2]
  assign fanout_out_12 = gated[FEEDBACK_INDEX]; // [RULE2]

  // Open drain: only ever pull low
  assign config_serial_data_pin_out = 1'h0;
  assign config_serial_data_pin_oe = q.sda_drive;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_addr_done;
    (q.state == ST_ADDR) && scl_fall && byte_full;
  endsequence

  sequence s_data_done(logic [1:0] idx);
    (q.state == ST_DATA) && scl_fall && byte_full && (q.byte_idx == idx);
  endsequence

  AST_RESET_ALL_ENABLED: assert property ($past(!rst_n) |-> q.enable == ENABLE_RESET) // [RULE4]
    else $error("enables not all set after reset");

  AST_ADDR_MATCH_ACK: assert property ( // [RULE7]
    s_addr_done and (q.shift == {CFG_TARGET_ADDR, DIR_WRITE})
    |=> config_serial_data_pin_oe && (q.state == ST_ADDR_ACK))
    else $error("matching write address not acknowledged");

  AST_ADDR_MISMATCH_QUIET: assert property ( // [RULE7]
    s_addr_done and (q.shift != {CFG_TARGET_ADDR, DIR_WRITE})
    |=> !config_serial_data_pin_oe && (q.state == ST_IDLE))
    else $error("foreign address or read was acknowledged");

  AST_MSB_FIRST: assert property ( // [RULE5]
    (q.state == ST_DATA) && scl_rise && !byte_full
    |=> q.shift == {$past(q.shift[6:0]), $past(q.sda_s2)})
    else $error("serial bit not shifted in msb first");

  AST_BYTE0_MAP: assert property (s_data_done(BYTE_LOW_GROUP) // [RULE8]
    |=> {q.enable[5:4], q.enable[3:0]} == {$past(q.shift[7:6]), $past(q.shift[3:0])})
    else $error("byte 0 mapped to wrong outputs");

  AST_BYTE1_MAP: assert property (s_data_done(BYTE_MID_GROUP) // [RULE9]
    |=> {q.enable[11:8], q.enable[7:6]} == {$past(q.shift[7:4]), $past(q.shift[1:0])})
    else $error("byte 1 mapped to wrong outputs");

  AST_BYTE2_MAP: assert property (s_data_done(BYTE_HIGH_GROUP) // [RULE10]
    |=> q.enable[12] == $past(q.shift[6]) && q.enable[11:0] == $past(q.enable[11:0]))
    else $error("byte 2 mapped to wrong outputs");

  AST_BYTE_ORDER: assert property (s_data_done(BYTE_LOW_GROUP) // [RULE5]
    |=> q.byte_idx == BYTE_MID_GROUP)
    else $error("byte index did not advance after byte 0");

  AST_ENABLE_ONLY_ON_BYTE: assert property ( // [RULE3]
    !((q.state == ST_DATA) && scl_fall && byte_full) |=> $stable(q.enable))
    else $error("enables changed outside a completed data byte");

endmodule : clock_fanout_output_enables

`default_nettype wire

/* File: design/clock_fanout_pkg.sv */
// Shared constants and types for the clock fan-out block
package clock_fanout_pkg;

  // ==========================================================
  // Output grouping
  localparam int NUM_OUTPUTS = 13;
  localparam int NUM_MEMORY_OUTPUTS = 12;
  localparam int FEEDBACK_INDEX = 12;

  // ==========================================================
  // Serial link framing
  localparam logic [6:0] CFG_TARGET_ADDR = 7'h69;
  localparam logic DIR_WRITE = 1'h0;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] NUM_CFG_BYTES = 2'h3;

  // ==========================================================
  // Configuration byte indices
  localparam logic [1:0] BYTE_LOW_GROUP = 2'h0;
  localparam logic [1:0] BYTE_MID_GROUP = 2'h1;
  localparam logic [1:0] BYTE_HIGH_GROUP = 2'h2;

  // ==========================================================
  // Field positions inside the configuration bytes
  localparam int LOW_OUT5_BIT = 7;
  localparam int LOW_OUT4_BIT = 6;
  localparam int LOW_OUT3_0_LSB = 0;
  localparam int MID_OUT11_8_LSB = 4;
  localparam int MID_OUT7_6_LSB = 0;
  localparam int HIGH_OUT12_BIT = 6;

  // ==========================================================
  // Values after reset
  localparam logic [NUM_OUTPUTS-1:0] ENABLE_RESET = 13'h1fff;

  // ==========================================================
  // Link receiver states
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ADDR = 5'h02,
    ST_ADDR_ACK = 5'h04,
    ST_DATA = 5'h08,
    ST_DATA_ACK = 5'h10
  } link_state_type;

  // Complete state of the configuration receiver
  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_d;
    logic sda_s1;
    logic sda_s2;
    logic sda_d;
    logic buf_s1;
    logic buf_s2;
    link_state_type state;
    logic [7:0] shift;
    logic [3:0] bit_cnt;
    logic [1:0] byte_idx;
    logic [NUM_OUTPUTS-1:0] enable;
    logic sda_drive;
  } ctrl_type;

  localparam ctrl_type CTRL_RESET = '{
    scl_s1: 1'h1, scl_s2: 1'h1, scl_d: 1'h1,
    sda_s1: 1'h1, sda_s2: 1'h1, sda_d: 1'h1,
    buf_s1: 1'h0, buf_s2: 1'h0,
    state: ST_IDLE, shift: 8'h00, bit_cnt: 4'h0, byte_idx: 2'h0,
    enable: ENABLE_RESET, sda_drive: 1'h0
  };

endpackage : clock_fanout_pkg

/* File: design/clock_gate_bank.sv */
// Glitch-free gating of one clock level onto a bank of outputs
`timescale 1ns/1ps
`default_nettype none

module clock_gate_bank
  import clock_fanout_pkg::*;
#(
  parameter int WIDTH = 13,
  parameter logic [WIDTH-1:0] RESET_ENABLE = '1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_level,
  input wire logic [WIDTH-1:0] enable,
  output logic [WIDTH-1:0] gated
);

  typedef struct packed {
    logic [WIDTH-1:0] applied;
    logic [WIDTH-1:0] out;
  } gate_type;

  gate_type q;
  gate_type next_q;

  // ==========================================================
  // Gating
  // Enables are only taken while the source is low, so a change can
  // never chop a high phase short; the cost is up to one phase of latency.
  always_comb begin
    next_q = q;
    next_q.applied = clk_level ? q.applied : enable; // [RULE11]
    next_q.out = {WIDTH{clk_level}} & next_q.applied; // [RULE1] [RULE11]
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q.applied <= RESET_ENABLE;
      q.out <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign gated = q.out;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_DISABLED_STAYS_LOW: assert property ((q.out & ~q.applied) == '0) // [RULE11]
    else $error("disabled output is not held low");

  AST_FROZEN_WHILE_HIGH: assert property ( // [RULE11]
    clk_level ##1 clk_level |-> $stable(q.applied))
    else $error("enable changed during a high phase");

  AST_FOLLOWS_SOURCE: assert property ( // [RULE1]
    ##1 q.out == ($past({WIDTH{clk_level}}) & q.applied))
    else $error("enabled output does not follow the source clock");

  // An output may only toggle right after a source edge, so no runt pulse
  AST_EDGES_TRACK_SOURCE: assert property ( // [RULE11]
    ((q.out ^ $past(q.out)) & ~{WIDTH{$past(clk_level) ^ $past(clk_level, 2)}}) == '0)
    else $error("output toggled without a source edge");

endmodule : clock_gate_bank

`default_nettype wire

/* File: dv/serial_master_model.sv */
// Behavioural two-wire master that loads the output enables
`timescale 1ns/1ps
`default_nettype none

module serial_master_model (
  input wire logic sda_wire,
  output logic scl,
  output logic sda_low
);
  logic ack;
  event ack_ev;

  // ====
  // Bit slot: data moves only while clock low
  task bit_out(input logic b);
    sda_low = ~b;
    #200 scl = 1'b1;
    #400 scl = 1'b0;
    #200;
  endtask : bit_out

  // Answer slot: released line reads high via pull-up unless device pulls
  task ack_slot;
    sda_low = 1'b0;
    #200 scl = 1'b1;
    #200 ack = ~sda_wire;
    ->ack_ev;
    #200 scl = 1'b0;
    #200;
  endtask : ack_slot

  // ====
  // Whole write frame; clock stands high outside frames
  task write_frame(input logic [7:0] addr_rw, input int n, input logic [31:0] data);
    int i;
    int k;
    // Called just after a clk edge; every later step is whole clk periods on
    sda_low = 1'b1;
    #400 scl = 1'b0;
    #200;
    for (k = 7; k >= 0; k--) bit_out(addr_rw[k]);
    ack_slot;
    // Stop early on a refused answer, the device has gone idle
    for (i = 0; i < n && ack; i++) begin
      for (k = 7; k >= 0; k--) bit_out(data[8*i+k]);
      ack_slot;
    end
    sda_low = 1'b1;
    #200 scl = 1'b1;
    #400 sda_low = 1'b0;
    #400;
  endtask : write_frame

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    ack = 1'b0;
  end
endmodule : serial_master_model

`default_nettype wire

/* File: dv/clock_fanout_output_enables_tb_top.sv */
// Self-checking bench for the clock fan-out enable block
`timescale 1ns/1ps
`default_nettype none

module clock_fanout_output_enables_tb_top;
  import clock_fanout_pkg::*;
  logic clk, rst_n, buf_in, scl, sda_low, sda_out, sda_oe, fanout_out_12;
  wire logic sda_wire;
  logic [NUM_MEMORY_OUTPUTS-1:0] fanout_out;
  logic [NUM_OUTPUTS-1:0] model, seen;
  logic exp_ack_q[$];
  logic [NUM_OUTPUTS-1:0] exp_mask_q[$];
  logic [31:0] rng;
  int n_errors, cmp_count, t;
  event meas_ev;

  // Open-drain wire resolved from both parties
  assign sda_wire = ~(sda_low | (sda_oe & ~sda_out));

  clock_fanout_output_enables clock_fanout_output_enables_inst (
    .clk(clk), .rst_n(rst_n), .buf_in(buf_in), .serial_clock_pin(scl),
    .config_serial_data_pin_in(sda_wire), .config_serial_data_pin_out(sda_out),
    .config_serial_data_pin_oe(sda_oe), .fanout_out(fanout_out),
    .fanout_out_12(fanout_out_12));
  serial_master_model serial_master_model_inst (.sda_wire(sda_wire), .scl(scl),
    .sda_low(sda_low));

  // ====
  // Clocks; source clock slow so oversampling tracks it
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    buf_in = 1'b0;
    #51;
    forever #1000 buf_in = ~buf_in;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  // Expected enables after one byte lands
  function automatic logic [12:0] apply(input logic [12:0] m, input int i, input logic [7:0] d);
    case (i)
      0: begin
        m[5:4] = d[7:6];
        m[3:0] = d[3:0];
      end
      1: begin
        m[11:8] = d[7:4];
        m[7:6] = d[1:0];
      end
      2: m[12] = d[6];
      default: ;
    endcase
    return m;
  endfunction : apply

  // ====
  // Compare tasks
  task check_ack(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t ack got %b exp %b", $time, got, exp);
    end
  endtask : check_ack
  task check_mask(input logic [12:0] got, input logic [12:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t outputs seen %h exp %h", $time, got, exp);
    end
  endtask : check_mask

  // Watchers pop the oldest note as each result appears
  always @(serial_master_model_inst.ack_ev) begin
    check_ack(serial_master_model_inst.ack, exp_ack_q.pop_front());
  end
  always @(meas_ev) begin
    seen = '0;
    repeat (40) begin
      @(posedge clk);
      // Look once the edge's register updates have settled
      #1;
      seen |= {fanout_out_12, fanout_out};
    end
    check_mask(seen, exp_mask_q.pop_front());
  end

  task measure;
    exp_mask_q.push_back(model);
    ->meas_ev;
    repeat (45) @(posedge clk);
    #1;
  endtask : measure

  task frame(input logic [7:0] addr_rw, input int n, input logic [31:0] data, input logic ok);
    int i;
    exp_ack_q.push_back(ok);
    for (i = 0; i < n && ok; i++) begin
      exp_ack_q.push_back(1'b1);
      model = apply(model, i, data[8*i +: 8]);
    end
    serial_master_model_inst.write_frame(addr_rw, n, data);
    repeat (25) @(posedge clk);
    measure;
    $display("test done addr %h bytes %0d", addr_rw, n);
  endtask : frame

  task finish_test;
    $display("checks %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  // ====
  // Main sequence
  initial begin
    rst_n = 1'b0;
    rng = 32'hcf99c221;
    model = 13'h1fff;
    n_errors = 0;
    cmp_count = 0;
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (10) @(posedge clk);
    #1;
    measure;
    $display("test done power-up enables");
    // Reserved bits kept zero; 1..4 bytes covers partial and surplus bytes
    for (t = 0; t < 8; t++) begin
      rng = xs(rng);
      frame({7'h69, 1'b0}, 1 + t % 4, rng & 32'h0040f3cf, 1'b1);
    end
    frame({7'h69, 1'b0}, 3, 32'h0, 1'b1);
    // Mid-run reset with every output disabled must bring them all back
    rst_n = 1'b0;
    model = 13'h1fff;
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (10) @(posedge clk);
    #1;
    measure;
    $display("test done mid-run reset");
    frame({7'h68, 1'b0}, 3, 32'h0040f3cf, 1'b0);
    frame({7'h69, 1'b1}, 3, 32'h0040f3cf, 1'b0);
    frame({7'h69, 1'b0}, 3, 32'h0040f3cf, 1'b1);
    finish_test;
  end

  // Hang guard, run needs about 0.4 milliseconds
  initial begin
    #3000000;
    n_errors++;
    $display("BAD %0t watchdog expired", $time);
    finish_test;
  end
endmodule : clock_fanout_output_enables_tb_top

`default_nettype wire
